// ===== hw/cabe_alu.v
`timescale 1ns/1ps
`include "cabe_defs.vh"

module cabe_alu (
  input  wire [3:0]  op_in,
  input  wire [15:0] a_in,
  input  wire [15:0] b_in,
  input  wire        carry_in,
  input  wire        half_in,
  output reg  [15:0] res_out,
  output reg         n_out,
  output reg         z_out,
  output reg         v_out,
  output reg         c_out,
  output reg         h_out
);

  reg [16:0] wide;
  reg [4:0]  nib;
  reg [7:0]  adj;
  reg        word;

  always @* begin
    wide  = 17'h00000;
    nib   = 5'h00;
    adj   = 8'h00;
    word  = 1'b0;
    res_out = a_in;
    v_out = 1'b0;
    c_out = carry_in;
    h_out = half_in;
    case (op_in)
      `CABE_ALU_ADD8: begin
        wide = {9'h000, a_in[7:0]} + {9'h000, b_in[7:0]} + {16'h0000, carry_in};
        nib  = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        res_out = {a_in[15:8], wide[7:0]};
        c_out = wide[8];
        h_out = nib[4];
        v_out = (a_in[7] == b_in[7]) && (wide[7] != a_in[7]);
      end
      `CABE_ALU_SUB8: begin
        // bit 8 of the wrapped difference is the borrow
        wide = {9'h000, a_in[7:0]} - {9'h000, b_in[7:0]} - {16'h0000, carry_in};
        nib  = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, carry_in};
        res_out = {a_in[15:8], wide[7:0]};
        c_out = wide[8];
        h_out = nib[4];
        v_out = (a_in[7] != b_in[7]) && (wide[7] != a_in[7]);
      end
      `CABE_ALU_ADD16: begin
        word = 1'b1;
        wide = {1'b0, a_in} + {1'b0, b_in} + {16'h0000, carry_in};
        res_out = wide[15:0];
        c_out = wide[16];
        v_out = (a_in[15] == b_in[15]) && (wide[15] != a_in[15]);
      end
      `CABE_ALU_SUB16: begin
        word = 1'b1;
        wide = {1'b0, a_in} - {1'b0, b_in} - {16'h0000, carry_in};
        res_out = wide[15:0];
        c_out = wide[16];
        v_out = (a_in[15] != b_in[15]) && (wide[15] != a_in[15]);
      end
      `CABE_ALU_AND8: res_out = {a_in[15:8], a_in[7:0] & b_in[7:0]};
      `CABE_ALU_OR8:  res_out = {a_in[15:8], a_in[7:0] | b_in[7:0]};
      `CABE_ALU_XOR8: res_out = {a_in[15:8], a_in[7:0] ^ b_in[7:0]};
      `CABE_ALU_AND16: begin
        word = 1'b1;
        res_out = a_in & b_in;
      end
      `CABE_ALU_OR16: begin
        word = 1'b1;
        res_out = a_in | b_in;
      end
      `CABE_ALU_XOR16: begin
        word = 1'b1;
        res_out = a_in ^ b_in;
      end
      `CABE_ALU_DAA, `CABE_ALU_DAS: begin
        // no half carry in the flags, so the adjust trusts h kept here
        c_out = carry_in || (a_in[7:0] > `CABE_BCD_MAX);
        if (c_out) begin
          adj = adj | `CABE_BCD_ADJ_HI;
        end
        if (half_in || (a_in[3:0] > `CABE_BCD_NIB_MAX)) begin
          adj = adj | `CABE_BCD_ADJ_LO;
        end
        if (op_in == `CABE_ALU_DAA) begin
          res_out = {a_in[15:8], a_in[7:0] + adj};
          v_out = !a_in[7] && res_out[7];
        end else begin
          res_out = {a_in[15:8], a_in[7:0] - adj};
          v_out = a_in[7] && !res_out[7];
        end
      end
      default: res_out = a_in;
    endcase
    n_out = word ? res_out[15] : res_out[7];
    z_out = word ? (res_out == 16'h0000) : (res_out[7:0] == 8'h00);
  end

endmodule

// ===== hw/cabe_core.v
`timescale 1ns/1ps
`include "cabe_defs.vh"

module cabe_core (
  input  wire        clock_in,
  input  wire        srst_in,
  input  wire        start_in,
  input  wire [7:0]  opcode_in,
  input  wire [7:0]  rel_offset_in,
  input  wire [7:0]  bit_data_in,
  input  wire [15:0] saved_pc_in,
  input  wire [3:0]  saved_flags_in,
  input  wire        byte_load_in,
  input  wire        word_load_in,
  input  wire [15:0] load_data_in,
  input  wire        gr_load_in,
  input  wire [2:0]  gr_load_index_in,
  input  wire [7:0]  gr_load_data_in,
  input  wire [2:0]  gr_sel_in,
  output reg         busy_out,
  output reg         done_out,
  output reg  [15:0] acc_out,
  output reg  [15:0] temp_out,
  output reg  [15:0] pc_out,
  output reg         flag_n_out,
  output reg         flag_z_out,
  output reg         flag_v_out,
  output reg         flag_c_out,
  output reg  [7:0]  gr_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state;
  reg [4:0]  cnt;
  reg        half;
  reg [7:0]  gr [0:7];
  integer    i;

  // results held from acceptance until the last cycle
  reg [15:0] p_acc;
  reg [15:0] p_temp;
  reg [15:0] p_pc;
  reg        p_n;
  reg        p_z;
  reg        p_v;
  reg        p_c;
  reg        p_half;
  reg        p_gr_we;
  reg [2:0]  p_gr_idx;
  reg [7:0]  p_gr_val;

  reg [3:0]  alu_op;
  reg [15:0] alu_a;
  reg [15:0] alu_b;
  reg        alu_cin;
  wire [15:0] alu_res;
  wire       alu_n;
  wire       alu_z;
  wire       alu_v;
  wire       alu_c;
  wire       alu_h;

  reg [15:0] next_acc;
  reg [15:0] next_temp;
  reg [15:0] next_pc;
  reg        next_n;
  reg        next_z;
  reg        next_v;
  reg        next_c;
  reg        next_half;
  reg        next_gr_we;
  reg [7:0]  next_gr_val;
  reg [4:0]  next_cyc;
  reg        bit_val;

  wire [3:0] row = opcode_in[7:4];
  wire [3:0] col = opcode_in[3:0];

  function [15:0] rel_target;
    input [15:0] pc;
    input [15:0] len;
    input [7:0]  rel;
    begin
      rel_target = pc + len + {{8{rel[7]}}, rel};
    end
  endfunction

  function br_taken;
    input [2:0] sel;
    input       n;
    input       z;
    input       v;
    input       c;
    begin
      case (sel)
        3'h0:    br_taken = !c;
        3'h1:    br_taken = c;
        3'h2:    br_taken = !n;
        3'h3:    br_taken = n;
        3'h4:    br_taken = !z;
        3'h5:    br_taken = z;
        3'h6:    br_taken = !(v ^ n);
        default: br_taken = v ^ n;
      endcase
    end
  endfunction

  cabe_alu u_alu (
    .op_in    (alu_op),
    .a_in     (alu_a),
    .b_in     (alu_b),
    .carry_in (alu_cin),
    .half_in  (half),
    .res_out  (alu_res),
    .n_out    (alu_n),
    .z_out    (alu_z),
    .v_out    (alu_v),
    .c_out    (alu_c),
    .h_out    (alu_h)
  );

  // operand steering, decoded by map row then column
  always @* begin
    alu_op  = `CABE_ALU_ADD8;
    alu_a   = acc_out;
    alu_b   = {8'h00, gr[opcode_in[2:0]]};
    alu_cin = flag_c_out;
    case (row)
      `CABE_ROW_ADD_WITH_CARRY_OP: begin
        if (col == `CABE_COL_BYTE) begin
          alu_b = temp_out;
        end else if (col == `CABE_COL_WORD) begin
          alu_op = `CABE_ALU_ADD16;
          alu_b  = temp_out;
        end
      end
      `CABE_ROW_SUBTRACT_WITH_BORROW_OP: begin
        alu_op = `CABE_ALU_SUB8;
        if (col == `CABE_COL_BYTE) begin
          alu_a = {acc_out[15:8], temp_out[7:0]};
          alu_b = acc_out;
        end else if (col == `CABE_COL_WORD) begin
          alu_op = `CABE_ALU_SUB16;
          alu_a  = temp_out;
          alu_b  = acc_out;
        end
      end
      `CABE_ROW_XOR: begin
        alu_b  = temp_out;
        alu_op = (col == `CABE_COL_WORD) ? `CABE_ALU_XOR16 : `CABE_ALU_XOR8;
      end
      `CABE_ROW_AND: begin
        alu_b  = temp_out;
        alu_op = (col == `CABE_COL_WORD) ? `CABE_ALU_AND16 : `CABE_ALU_AND8;
      end
      `CABE_ROW_OR: begin
        alu_b  = temp_out;
        alu_op = (col == `CABE_COL_WORD) ? `CABE_ALU_OR16 : `CABE_ALU_OR8;
      end
      `CABE_ROW_DAA: alu_op = `CABE_ALU_DAA;
      `CABE_ROW_DAS: alu_op = `CABE_ALU_DAS;
      `CABE_ROW_INC, `CABE_ROW_DEC: begin
        alu_op  = (row == `CABE_ROW_INC) ? `CABE_ALU_ADD8 : `CABE_ALU_SUB8;
        alu_a   = {8'h00, gr[opcode_in[2:0]]};
        alu_b   = 16'h0001;
        alu_cin = 1'b0;
      end
      default: alu_op = `CABE_ALU_ADD8;
    endcase
  end

  // architectural effect of the opcode on the current state
  always @* begin
    next_acc    = acc_out;
    next_temp   = temp_out;
    next_pc     = pc_out + `CABE_LEN_ONE;
    next_n      = flag_n_out;
    next_z      = flag_z_out;
    next_v      = flag_v_out;
    next_c      = flag_c_out;
    next_half   = half;
    next_gr_we  = 1'b0;
    next_gr_val = alu_res[7:0];
    next_cyc    = `CABE_CYC_ONE;
    bit_val     = bit_data_in[opcode_in[2:0]];
    case (row)
      `CABE_ROW_ADD_WITH_CARRY_OP, `CABE_ROW_SUBTRACT_WITH_BORROW_OP: begin
        if (opcode_in[3] || col == `CABE_COL_BYTE ||
            col == `CABE_COL_WORD) begin
          next_acc  = alu_res;
          next_n    = alu_n;
          next_z    = alu_z;
          next_v    = alu_v;
          next_c    = alu_c;
          next_half = alu_h;
          if (opcode_in[3]) begin
            next_cyc = `CABE_CYC_ADD_WITH_CARRY_OP_REG;
          end else if (col == `CABE_COL_BYTE) begin
            next_cyc = `CABE_CYC_BYTEOP;
          end else begin
            next_cyc = `CABE_CYC_WORDOP;
          end
        end else if (row == `CABE_ROW_SUBTRACT_WITH_BORROW_OP && col == `CABE_COL_INTERRUPT_RETURN_OP) begin
          next_pc  = saved_pc_in;
          next_n   = saved_flags_in[`CABE_PS_N];
          next_z   = saved_flags_in[`CABE_PS_Z];
          next_v   = saved_flags_in[`CABE_PS_V];
          next_c   = saved_flags_in[`CABE_PS_C];
          next_cyc = `CABE_CYC_INTERRUPT_RETURN_OP;
        end
      end
      `CABE_ROW_XOR, `CABE_ROW_AND, `CABE_ROW_OR: begin
        if (col == `CABE_COL_BYTE || col == `CABE_COL_WORD) begin
          next_acc = alu_res;
          next_n   = alu_n;
          next_z   = alu_z;
          next_v   = 1'b0;
          next_cyc = (col == `CABE_COL_WORD) ? `CABE_CYC_WORDOP
                                              : `CABE_CYC_BYTEOP;
        end
      end
      `CABE_ROW_DAA, `CABE_ROW_DAS: begin
        if (col == `CABE_COL_ADJUST) begin
          next_acc = alu_res;
          next_n   = alu_n;
          next_z   = alu_z;
          next_v   = alu_v;
          next_c   = alu_c;
          next_cyc = `CABE_CYC_DECADJ;
        end else if (col == `CABE_COL_FLAGOP) begin
          next_c = (row == `CABE_ROW_DAS);
        end
      end
      `CABE_ROW_MUL: begin
        if (col == `CABE_COL_MULDIV) begin
          next_acc = acc_out[7:0] * temp_out[7:0];
          next_cyc = `CABE_CYC_MUL;
        end
      end
      `CABE_ROW_DIV: begin
        if (col == `CABE_COL_MULDIV) begin
          // upper bytes forced to zero, so a wide quotient is truncated
          if (acc_out[7:0] == 8'h00) begin
            next_acc  = {8'h00, `CABE_DIV0_QUOT};
            next_temp = {8'h00, temp_out[7:0]};
          end else begin
            next_acc  = (temp_out / {8'h00, acc_out[7:0]}) & 16'h00ff;
            next_temp = temp_out % {8'h00, acc_out[7:0]};
          end
          next_cyc = `CABE_CYC_DIV;
        end
      end
      `CABE_ROW_BBIT: begin
        next_z   = !bit_val;
        next_cyc = `CABE_CYC_BBIT;
        next_pc  = pc_out + `CABE_LEN_BBIT;
        if (bit_val == opcode_in[3]) begin
          next_pc = rel_target(pc_out, `CABE_LEN_BBIT, rel_offset_in);
        end
      end
      `CABE_ROW_INC, `CABE_ROW_DEC: begin
        if (opcode_in[3]) begin
          next_gr_we = 1'b1;
          next_n     = alu_n;
          next_z     = alu_z;
          next_v     = alu_v;
          next_cyc   = `CABE_CYC_INCDEC;
        end
      end
      `CABE_ROW_BRANCH: begin
        if (opcode_in[3]) begin
          next_cyc = `CABE_CYC_BRANCH;
          next_pc  = pc_out + `CABE_LEN_BRANCH;
          if (br_taken(opcode_in[2:0], flag_n_out, flag_z_out,
                       flag_v_out, flag_c_out)) begin
            next_pc = rel_target(pc_out, `CABE_LEN_BRANCH,
                                 rel_offset_in);
          end
        end else if (col == `CABE_COL_XPC) begin
          next_pc  = acc_out;
          next_acc = pc_out + `CABE_LEN_ONE;
          next_cyc = `CABE_CYC_XPC;
        end
      end
      default: next_cyc = `CABE_CYC_ONE;
    endcase
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      state      <= ST_IDLE;
      cnt        <= 5'd0;
      half       <= 1'b0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      acc_out    <= 16'h0000;
      temp_out   <= 16'h0000;
      pc_out     <= 16'h0000;
      flag_n_out <= 1'b0;
      flag_z_out <= 1'b0;
      flag_v_out <= 1'b0;
      flag_c_out <= 1'b0;
      gr_out     <= 8'h00;
      p_acc      <= 16'h0000;
      p_temp     <= 16'h0000;
      p_pc       <= 16'h0000;
      p_n        <= 1'b0;
      p_z        <= 1'b0;
      p_v        <= 1'b0;
      p_c        <= 1'b0;
      p_half     <= 1'b0;
      p_gr_we    <= 1'b0;
      p_gr_idx   <= 3'h0;
      p_gr_val   <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        gr[i] <= 8'h00;
      end
    end else begin
      done_out <= 1'b0;
      gr_out   <= gr[gr_sel_in];
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            // results fixed now; loads are refused while busy
            p_acc    <= next_acc;
            p_temp   <= next_temp;
            p_pc     <= next_pc;
            p_n      <= next_n;
            p_z      <= next_z;
            p_v      <= next_v;
            p_c      <= next_c;
            p_half   <= next_half;
            p_gr_we  <= next_gr_we;
            p_gr_idx <= opcode_in[2:0];
            p_gr_val <= next_gr_val;
            cnt      <= next_cyc;
            busy_out <= 1'b1;
            state    <= ST_RUN;
          end else begin
            if (byte_load_in) begin
              acc_out[7:0]  <= load_data_in[7:0];
              temp_out[7:0] <= acc_out[7:0];
              flag_n_out    <= load_data_in[7];
              flag_z_out    <= (load_data_in[7:0] == 8'h00);
            end else if (word_load_in) begin
              acc_out    <= load_data_in;
              temp_out   <= acc_out;
              flag_n_out <= load_data_in[15];
              flag_z_out <= (load_data_in == 16'h0000);
            end
            if (gr_load_in) begin
              gr[gr_load_index_in] <= gr_load_data_in;
            end
          end
        end
        ST_RUN: begin
          if (cnt == `CABE_CYC_ONE) begin
            acc_out    <= p_acc;
            temp_out   <= p_temp;
            pc_out     <= p_pc;
            flag_n_out <= p_n;
            flag_z_out <= p_z;
            flag_v_out <= p_v;
            flag_c_out <= p_c;
            half       <= p_half;
            if (p_gr_we) begin
              gr[p_gr_idx] <= p_gr_val;
            end
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state    <= ST_IDLE;
          end else begin
            cnt <= cnt - `CABE_CYC_ONE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== hw/cabe_defs.vh
`ifndef CABE_DEFS_VH
`define CABE_DEFS_VH

// opcode map rows (upper nibble)
`define CABE_ROW_MUL      4'h0
`define CABE_ROW_DIV      4'h1
`define CABE_ROW_ADD_WITH_CARRY_OP     4'h2
`define CABE_ROW_SUBTRACT_WITH_BORROW_OP     4'h3
`define CABE_ROW_XOR      4'h5
`define CABE_ROW_AND      4'h6
`define CABE_ROW_OR       4'h7
`define CABE_ROW_DAA      4'h8
`define CABE_ROW_DAS      4'h9
`define CABE_ROW_BBIT     4'hb
`define CABE_ROW_INC      4'hc
`define CABE_ROW_DEC      4'hd
`define CABE_ROW_BRANCH   4'hf

// opcode map columns (lower nibble)
`define CABE_COL_INTERRUPT_RETURN_OP     4'h0
`define CABE_COL_MULDIV   4'h1
`define CABE_COL_FLAGOP   4'h1
`define CABE_COL_BYTE     4'h2
`define CABE_COL_WORD     4'h3
`define CABE_COL_ADJUST   4'h4
`define CABE_COL_XPC      4'h4

// instruction cycle counts
`define CABE_CYC_ONE      5'd1
`define CABE_CYC_BYTEOP   5'd2
`define CABE_CYC_DECADJ   5'd2
`define CABE_CYC_ADD_WITH_CARRY_OP_REG 5'd3
`define CABE_CYC_WORDOP   5'd3
`define CABE_CYC_BRANCH   5'd3
`define CABE_CYC_XPC      5'd3
`define CABE_CYC_INCDEC   5'd4
`define CABE_CYC_BBIT     5'd5
`define CABE_CYC_INTERRUPT_RETURN_OP     5'd6
`define CABE_CYC_MUL      5'd19
`define CABE_CYC_DIV      5'd21

// instruction lengths in bytes
`define CABE_LEN_ONE      16'h0001
`define CABE_LEN_BRANCH   16'h0002
`define CABE_LEN_BBIT     16'h0003

// saved status nibble layout
`define CABE_PS_N         3
`define CABE_PS_Z         2
`define CABE_PS_V         1
`define CABE_PS_C         0

// alu operation select
`define CABE_ALU_ADD8     4'h0
`define CABE_ALU_SUB8     4'h1
`define CABE_ALU_ADD16    4'h2
`define CABE_ALU_SUB16    4'h3
`define CABE_ALU_AND8     4'h4
`define CABE_ALU_OR8      4'h5
`define CABE_ALU_XOR8     4'h6
`define CABE_ALU_AND16    4'h7
`define CABE_ALU_OR16     4'h8
`define CABE_ALU_XOR16    4'h9
`define CABE_ALU_DAA      4'ha
`define CABE_ALU_DAS      4'hb

// decimal adjust constants
`define CABE_BCD_MAX      8'h99
`define CABE_BCD_NIB_MAX  4'h9
`define CABE_BCD_ADJ_HI   8'h60
`define CABE_BCD_ADJ_LO   8'h06

// quotient on divide by zero
`define CABE_DIV0_QUOT    8'hff

`endif

// ===== tb/cabe_core_checker.sv
`timescale 1ns/1ps
module cabe_core_checker (
  input wire        clock_in,
  input wire        srst_in,
  input wire        start_in,
  input wire [7:0]  opcode_in,
  input wire [7:0]  rel_offset_in,
  input wire [7:0]  bit_data_in,
  input wire [15:0] saved_pc_in,
  input wire [3:0]  saved_flags_in,
  input wire        byte_load_in,
  input wire        word_load_in,
  input wire [15:0] load_data_in,
  input wire        gr_load_in,
  input wire [2:0]  gr_load_index_in,
  input wire [7:0]  gr_load_data_in,
  input wire [2:0]  gr_sel_in,
  input wire        busy_out,
  input wire        done_out,
  input wire [15:0] acc_out,
  input wire [15:0] temp_out,
  input wire [15:0] pc_out,
  input wire        flag_n_out,
  input wire        flag_z_out,
  input wire        flag_v_out,
  input wire        flag_c_out,
  input wire [7:0]  gr_out
);
  wire        take = start_in && !busy_out;
  wire [3:0]  flags = {flag_n_out, flag_z_out, flag_v_out, flag_c_out};
  wire        bit_sel = bit_data_in[opcode_in[2:0]];
  wire        raw = opcode_in[2] ?
                    (opcode_in[1] ? flag_v_out ^ flag_n_out : flag_z_out) :
                    (opcode_in[1] ? flag_n_out : flag_c_out);
  wire [15:0] br_next = pc_out + 16'h0002 + ((raw ~^ opcode_in[0]) ?
                        {{8{rel_offset_in[7]}}, rel_offset_in} : 16'h0000);
  wire [15:0] bl_t = {temp_out[15:8], acc_out[7:0]};
  wire [15:0] bl_a = {acc_out[15:8], load_data_in[7:0]};
  wire        wlog = opcode_in == 8'h53 || opcode_in == 8'h63 ||
                     opcode_in == 8'h73;
  wire        blog = opcode_in == 8'h52 || opcode_in == 8'h62 ||
                     opcode_in == 8'h72;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  mul_timing_a: assert property (
    take && opcode_in == 8'h01 |-> ##20 done_out && flags == $past(flags, 20))
    else $error("multiply timing or flags wrong");
  div_timing_a: assert property (
    take && opcode_in == 8'h11 |-> ##22 done_out &&
    temp_out[15:8] == 8'h00 && acc_out[15:8] == 8'h00)
    else $error("divide timing or upper bytes wrong");
  incdec_carry_a: assert property (
    take && opcode_in[7:5] == 3'b110 && opcode_in[3] |->
    ##5 done_out && flag_c_out == $past(flag_c_out, 5))
    else $error("register step timing or carry wrong");
  bit_branch_a: assert property (
    take && opcode_in[7:4] == 4'hb |-> ##6 done_out &&
    flag_z_out == !$past(bit_sel, 6) && flag_n_out == $past(flag_n_out, 6))
    else $error("bit test branch timing or flags wrong");
  word_logic_a: assert property (
    take && wlog |-> ##4 done_out && !flag_v_out &&
    flag_c_out == $past(flag_c_out, 4))
    else $error("word logic flags wrong");
  byte_logic_a: assert property (
    take && blog |-> ##3 done_out && !flag_v_out &&
    flag_c_out == $past(flag_c_out, 3))
    else $error("byte logic flags wrong");
  pc_exchange_a: assert property (
    take && opcode_in == 8'hf4 |-> ##4 pc_out == $past(acc_out, 4) &&
    acc_out == $past(pc_out, 4) + 16'h0001)
    else $error("program counter exchange wrong");
  branch_target_a: assert property (
    take && opcode_in[7:3] == 5'h1f |-> ##4 done_out &&
    pc_out == $past(br_next, 4))
    else $error("relative branch target wrong");
  byte_load_a: assert property (
    byte_load_in && !busy_out && !start_in |=>
    acc_out == $past(bl_a) && temp_out == $past(bl_t))
    else $error("byte load copy wrong");
  int_return_a: assert property (
    take && opcode_in == 8'h30 |-> ##7 done_out &&
    flags == $past(saved_flags_in, 7))
    else $error("interrupt return flags wrong");
endmodule

// ===== tb/cabe_mem.sv
`timescale 1ns/1ps
module cabe_mem (
  input  wire        clock_in,
  input  wire [15:0] addr_in,
  output reg  [7:0]  rel_out,
  output reg  [7:0]  dir_out
);
  // operand bytes follow the opcode in notation order; fixed pattern
  always @(negedge clock_in) begin
    rel_out <= addr_in[2] ? 8'he0 : 8'h21;
    dir_out <= 8'h5a ^ addr_in[7:0];
  end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clock_in = 1'b0;
  reg         srst_in = 1'b1;
  reg         start_in = 1'b0;
  reg  [7:0]  opcode_in = 8'h00;
  reg  [15:0] saved_pc_in = 16'h0400;
  reg  [3:0]  saved_flags_in = 4'ha;
  reg         byte_load_in = 1'b0;
  reg         word_load_in = 1'b0;
  reg  [15:0] load_data_in = 16'h0000;
  reg         gr_load_in = 1'b0;
  reg  [2:0]  gr_load_index_in = 3'h0;
  reg  [7:0]  gr_load_data_in = 8'h00;
  reg  [2:0]  gr_sel_in = 3'h0;
  wire        busy_out, done_out, flag_n_out, flag_z_out, flag_v_out;
  wire        flag_c_out;
  wire [15:0] acc_out, temp_out, pc_out;
  wire [7:0]  gr_out, rel_offset_in, bit_data_in;
  wire [3:0]  flags = {flag_n_out, flag_z_out, flag_v_out, flag_c_out};
  integer     fails = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  reg  [15:0] exp_pc = 16'h0000;
  reg  [15:0] p;
  reg  [3:0]  fl;

  always #25 clock_in = ~clock_in;

  cabe_core u_dut (.clock_in(clock_in), .srst_in(srst_in),
    .start_in(start_in), .opcode_in(opcode_in),
    .rel_offset_in(rel_offset_in), .bit_data_in(bit_data_in),
    .saved_pc_in(saved_pc_in), .saved_flags_in(saved_flags_in),
    .byte_load_in(byte_load_in), .word_load_in(word_load_in),
    .load_data_in(load_data_in), .gr_load_in(gr_load_in),
    .gr_load_index_in(gr_load_index_in),
    .gr_load_data_in(gr_load_data_in), .gr_sel_in(gr_sel_in),
    .busy_out(busy_out), .done_out(done_out), .acc_out(acc_out),
    .temp_out(temp_out), .pc_out(pc_out), .flag_n_out(flag_n_out),
    .flag_z_out(flag_z_out), .flag_v_out(flag_v_out),
    .flag_c_out(flag_c_out), .gr_out(gr_out));
  cabe_mem u_mem (.clock_in(clock_in), .addr_in(pc_out),
    .rel_out(rel_offset_in), .dir_out(bit_data_in));

  task check(input [15:0] seen, input [15:0] expd);
    begin
      checks_done = checks_done + 1;
      if (seen !== expd) begin
        fails = fails + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expd);
      end
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // starts and ends at a falling edge, so calls run back to back
  task exec(input [7:0] op, input [15:0] len, input [4:0] cyc);
    reg [15:0] n;
    begin
      opcode_in = op;
      start_in = 1'b1;
      @(negedge clock_in);
      start_in = 1'b0;
      n = 16'h0000;
      while (!done_out && n < 16'h0028) begin
        @(negedge clock_in);
        n = n + 16'h0001;
      end
      check(n, {11'h000, cyc});
      exp_pc = exp_pc + len;
      check(pc_out, exp_pc);
    end
  endtask

  task load(input [1:0] kind, input [15:0] d);
    begin
      word_load_in = kind == 2'h0;
      byte_load_in = kind == 2'h1;
      gr_load_in = kind == 2'h2;
      load_data_in = d;
      gr_load_index_in = d[10:8];
      gr_load_data_in = d[7:0];
      @(negedge clock_in);
      word_load_in = 1'b0;
      byte_load_in = 1'b0;
      gr_load_in = 1'b0;
      @(negedge clock_in);
    end
  endtask

  task run(input [15:0] t, input [15:0] a, input c, input [7:0] op,
           input [15:0] ea, input [15:0] et, input [3:0] f,
           input [3:0] m, input [4:0] cyc);
    begin
      load(2'h0, t);
      load(2'h0, a);
      exec(c ? 8'h91 : 8'h81, 16'h0001, 5'h01);
      exec(op, 16'h0001, cyc);
      check(acc_out, ea);
      check(temp_out, et);
      check({12'h000, flags & m}, {12'h000, f & m});
      fl = f;
    end
  endtask

  // row f: flag branches, row b: bit tests; fl holds known flags
  task br(input [3:0] row);
    integer    i;
    reg [7:0]  rel;
    reg [7:0]  d;
    reg        raw;
    reg        bit_row;
    begin
      bit_row = row == 4'hb;
      for (i = bit_row ? 0 : 8; i < 16; i = i + 1) begin
        rel = exp_pc[2] ? 8'he0 : 8'h21;
        d = 8'h5a ^ exp_pc[7:0];
        case (i[2:1])
          2'h0: raw = fl[0];
          2'h1: raw = fl[3];
          2'h2: raw = fl[2];
          default: raw = fl[1] ^ fl[3];
        endcase
        if (bit_row) begin
          raw = d[i[2:0]];
          fl[2] = ~raw;
        end
        p = (bit_row ? 16'h0003 : 16'h0002) +
            ((raw == (bit_row ? i[3] : i[0])) ? {{8{rel[7]}}, rel} : 16'h0);
        exec({row, i[3:0]}, p, bit_row ? 5'h05 : 5'h03);
        check({12'h000, flags}, {12'h000, fl});
      end
    end
  endtask

  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      test_done;
    end
  end

  initial begin
    repeat (16) @(posedge clock_in);
    @(negedge clock_in);
    check(acc_out | temp_out | pc_out, 16'h0000);
    check({4'h0, flags, gr_out}, 16'h0000);
    srst_in = 1'b0;
    @(negedge clock_in);
    load(2'h0, 16'habcd);
    load(2'h0, 16'h1234);
    load(2'h1, 16'h0056);
    check(acc_out, 16'h1256);
    check(temp_out, 16'hab34);
    load(2'h2, 16'h0520);
    load(2'h2, 16'h027f);
    exec(8'h00, 16'h0001, 5'h01);
    run(16'h8000, 16'h8000, 1'b0, 8'h23, 16'h0000, 16'h8000, 4'h7, 4'hf, 5'h03);
    br(4'hf);
    br(4'hb);
    run(16'hf0f0, 16'h8f0f, 1'b1, 8'h63, 16'h8000, 16'hf0f0, 4'h9, 4'hf, 5'h03);
    run(16'h00f0, 16'h3410, 1'b1, 8'h22, 16'h3401, 16'h00f0, 4'h1, 4'hf, 5'h02);
    run(16'h1111, 16'h009a, 1'b0, 8'h84, 16'h0000, 16'h1111, 4'h5, 4'hf, 5'h02);
    run(16'h1111, 16'h0070, 1'b0, 8'h2d, 16'h0090, 16'h1111, 4'ha, 4'hf, 5'h03);
    run(16'h00aa, 16'h3455, 1'b0, 8'h52, 16'h34ff, 16'h00aa, 4'h8, 4'hf, 5'h02);
    br(4'hf);
    run(16'h1111, 16'h0010, 1'b1, 8'h3d, 16'h00ef, 16'h1111, 4'h9, 4'hf, 5'h03);
    run(16'h0005, 16'h0006, 1'b0, 8'h33, 16'hffff, 16'h0005, 4'h9, 4'hf, 5'h03);
    run(16'h0080, 16'h0001, 1'b0, 8'h32, 16'h007f, 16'h0080, 4'h2, 4'hf, 5'h02);
    run(16'h5555, 16'h5555, 1'b1, 8'h53, 16'h0000, 16'h5555, 4'h5, 4'hf, 5'h03);
    run(16'h0080, 16'h009b, 1'b0, 8'h94, 16'h0035, 16'h0080, 4'h3, 4'hf, 5'h02);
    run(16'h000f, 16'h00f0, 1'b1, 8'h62, 16'h0000, 16'h000f, 4'h5, 4'hf, 5'h02);
    run(16'h0080, 16'h0001, 1'b0, 8'h72, 16'h0081, 16'h0080, 4'h8, 4'hf, 5'h02);
    run(16'h0000, 16'h0000, 1'b0, 8'h73, 16'h0000, 16'h0000, 4'h4, 4'hf, 5'h03);
    br(4'hf);
    run(16'h340f, 16'h12ff, 1'b1, 8'h01, 16'h0ef1, 16'h340f, 4'h1, 4'hd, 5'h13);
    run(16'h1234, 16'h0050, 1'b0, 8'h11, 16'h003a, 16'h0014, 4'h0, 4'hd, 5'h15);
    run(16'h1234, 16'h0002, 1'b0, 8'h11, 16'h001a, 16'h0000, 4'h0, 4'hd,
        5'h15);
    run(16'h1234, 16'h0000, 1'b0, 8'h11, 16'h00ff, 16'h0034, 4'h4, 4'hd,
        5'h15);
    gr_sel_in = 3'h2;
    exec(8'h91, 16'h0001, 5'h01);
    exec(8'hca, 16'h0001, 5'h04);
    check({12'h000, flags}, 16'h000b);
    exec(8'hda, 16'h0001, 5'h04);
    check({12'h000, flags}, 16'h0003);
    @(negedge clock_in);
    check({8'h00, gr_out}, 16'h007f);
    load(2'h0, 16'h1234);
    p = exp_pc + 16'h0001;
    exec(8'hf4, 16'h1234 - exp_pc, 5'h03);
    check(acc_out, p);
    exec(8'h30, 16'h0400 - exp_pc, 5'h06);
    check({12'h000, flags}, 16'h000a);
    test_done;
  end
endmodule

bind cabe_core cabe_core_checker u_chk (.clock_in(clock_in),
  .srst_in(srst_in), .start_in(start_in), .opcode_in(opcode_in),
  .rel_offset_in(rel_offset_in), .bit_data_in(bit_data_in),
  .saved_pc_in(saved_pc_in), .saved_flags_in(saved_flags_in),
  .byte_load_in(byte_load_in), .word_load_in(word_load_in),
  .load_data_in(load_data_in), .gr_load_in(gr_load_in),
  .gr_load_index_in(gr_load_index_in), .gr_load_data_in(gr_load_data_in),
  .gr_sel_in(gr_sel_in), .busy_out(busy_out), .done_out(done_out),
  .acc_out(acc_out), .temp_out(temp_out), .pc_out(pc_out),
  .flag_n_out(flag_n_out), .flag_z_out(flag_z_out),
  .flag_v_out(flag_v_out), .flag_c_out(flag_c_out), .gr_out(gr_out));
